// ==== rtl/smhp_parser.sv ====
/*
  submessage header parser with per-message receiver context.
  takes whole messages as a byte stream (last byte marked), skips the message header,
  splits submessages, forwards bodies of known kinds through a 4-word fifo and keeps
  the receiver context that handlers may update. assumes the byte source and the
  handlers run on clk, and that software fills the kind table before traffic.
*/
// Functional notes
// R1 - header is kind, eight flags, 16-bit length
// R2 - flag 0 is always the byte-order flag
// R3 - body big-endian when flag clear, little otherwise
// R4 - flags 1..7 meaning depends on kind
// R5 - length counts contents only, not header
// R6 - nonzero length locates next submessage header
// R7 - zero length: last submessage, runs to end
// R8 - context persists across submessages of one message
// R9 - context reset at every message start
// R10 - initial version, vendor, prefixes, timestamp values
// R11 - unicast reply locator: transport, source address
// R12 - multicast reply locator: transport, invalid address/port
// R13 - truncated header or bad length: rest invalid
// R14 - unknown kind skipped by its length
// R15 - length read in header's own byte order
`timescale 1ns/1ps
`default_nettype none
`include "smhp_consts.svh"
module smhp_parser
  import smhp_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  input wire logic [7:0] inByte,
  input wire logic inValid,
  input wire logic inLast,
  output logic inReady,
  input wire logic [95:0] localPrefix,
  input wire logic [31:0] transportKind,
  input wire logic [127:0] srcAddr,
  input wire logic srcAddrValid,
  input wire logic updSrcValid,
  input wire logic [15:0] updSrcVersion,
  input wire logic [15:0] updSrcVendor,
  input wire logic [95:0] updSrcPrefix,
  input wire logic updDstValid,
  input wire logic [95:0] updDstPrefix,
  input wire logic updTsValid,
  input wire logic updTsHave,
  input wire logic [63:0] updTs,
  output logic subValid,
  input wire logic subReady,
  output logic [7:0] subByte,
  output logic [7:0] subKind,
  output logic [7:0] subFlags,
  output logic subFirst,
  output logic subLast,
  output logic subLittle,
  output logic subErr,
  output logic [15:0] ctxVersion,
  output logic [15:0] ctxVendor,
  output logic [95:0] ctxSrcPrefix,
  output logic [95:0] ctxDstPrefix,
  output logic ctxHaveTs,
  output logic [63:0] ctxTs,
  output logic [31:0] ucKind,
  output logic [127:0] ucAddr,
  output logic [31:0] ucPort,
  output logic [31:0] mcKind,
  output logic [127:0] mcAddr,
  output logic [31:0] mcPort
);
  // length in the byte order chosen by the header's own flag
  function automatic logic [15:0] smhpLen(input logic [7:0] first, input logic [7:0] second,
                                          input logic little);
    smhpLen = little ? {second, first} : {first, second};
  endfunction : smhpLen

  smhp_state_t st_q, st_d; // parser state
  logic [4:0] hdrCnt_q, hdrCnt_d; // message header bytes seen
  logic [7:0] kind_q, kind_d; // kind of the current submessage
  logic [7:0] flags_q, flags_d; // raw flags of the current submessage
  logic [7:0] lenLo_q, lenLo_d; // first length byte on the wire
  logic [15:0] left_q, left_d; // body bytes still to come
  logic toEnd_q, toEnd_d; // body runs to message end
  logic deliver_q, deliver_d; // kind known, body goes downstream
  logic first_q, first_d; // next body byte is the first
  logic enable_q, enable_d; // software enable
  logic [15:0] msgCnt_q, msgCnt_d; // messages finished cleanly
  logic [15:0] badCnt_q, badCnt_d; // messages cut short
  logic [31:0] regRdData_q, regRdData_d; // read data, one cycle after the strobe
  logic accept; // byte taken this cycle
  logic msgStart; // first byte of a message taken
  logic msgGood, msgBad; // message ends cleanly or invalid
  logic pushValid, pushReady; // fifo fill side
  logic [`SMHP_WORD_W-1:0] pushWord, popWord;
  logic pushErr, pushLast;
  logic [15:0] lenNow; // length decoded from the current header
  logic [7:0] kindInfo; // kind table entry for kind_q
  logic ramRd, ramWr;

  assign lenNow = smhpLen(lenLo_q, inByte, flags_q[`SMHP_E_BIT]); // see R15 see R2
  // stall the source while disabled or while a body byte waits for fifo room
  assign inReady = enable_q && !(st_q == SMHP_BODY && deliver_q && !pushReady);
  assign accept = inValid && inReady;
  assign ramRd = accept && st_q == SMHP_SID;
  assign ramWr = regWr && regAddr == `SMHP_REG_KIND;

  // parser state machine
  always_comb begin
    st_d = st_q;
    hdrCnt_d = hdrCnt_q;
    kind_d = kind_q;
    flags_d = flags_q;
    lenLo_d = lenLo_q;
    left_d = left_q;
    toEnd_d = toEnd_q;
    deliver_d = deliver_q;
    first_d = first_q;
    msgStart = 1'b0;
    msgGood = 1'b0;
    msgBad = 1'b0;
    pushValid = 1'b0;
    pushErr = 1'b0;
    pushLast = 1'b0;
    if (accept) begin
      case (st_q)
        SMHP_IDLE: begin
          msgStart = 1'b1; // see R9
          hdrCnt_d = 5'd1;
          if (inLast) begin
            msgBad = 1'b1; // message shorter than its header
          end else begin
            st_d = SMHP_MHDR;
          end
        end
        SMHP_MHDR: begin
          hdrCnt_d = hdrCnt_q + 5'd1;
          if (inLast) begin
            msgBad = 1'b1;
            st_d = SMHP_IDLE;
          end else if (hdrCnt_q == `SMHP_MSG_HDR_LEN - 5'd1) begin
            st_d = SMHP_SID;
          end
        end
        SMHP_SID: begin
          kind_d = inByte; // see R1
          if (inLast) begin
            msgBad = 1'b1; // see R13
            st_d = SMHP_IDLE;
          end else begin
            st_d = SMHP_SFLG;
          end
        end
        SMHP_SFLG: begin
          flags_d = inByte;
          if (inLast) begin
            msgBad = 1'b1; // see R13
            st_d = SMHP_IDLE;
          end else begin
            st_d = SMHP_SLEN0;
          end
        end
        SMHP_SLEN0: begin
          lenLo_d = inByte;
          if (inLast) begin
            msgBad = 1'b1; // see R13
            st_d = SMHP_IDLE;
          end else begin
            st_d = SMHP_SLEN1;
          end
        end
        SMHP_SLEN1: begin
          // length covers the body only, so counting starts after this byte
          left_d = lenNow; // see R5
          toEnd_d = (lenNow == `SMHP_LEN_TO_END); // see R7
          deliver_d = kindInfo[`SMHP_KT_KNOWN_BIT]; // see R14
          first_d = 1'b1;
          if (inLast && toEnd_d) begin
            msgGood = 1'b1; // empty final submessage
            st_d = SMHP_IDLE;
          end else if (inLast) begin
            msgBad = 1'b1; // length beyond the message, see R13
            st_d = SMHP_IDLE;
          end else begin
            st_d = SMHP_BODY;
          end
        end
        SMHP_BODY: begin
          pushValid = deliver_q; // see R14
          first_d = 1'b0;
          left_d = left_q - 16'd1;
          pushLast = toEnd_q ? inLast : (left_q == 16'd1 || inLast); // see R7
          if (!toEnd_q && inLast && left_q != 16'd1) begin
            msgBad = 1'b1; // length exceeds remaining bytes, see R6 see R13
            pushErr = 1'b1;
            st_d = SMHP_IDLE;
          end else if (inLast) begin
            msgGood = 1'b1;
            st_d = SMHP_IDLE;
          end else if (!toEnd_q && left_q == 16'd1) begin
            st_d = SMHP_SID; // see R6
          end
        end
        default: begin
          st_d = SMHP_IDLE;
        end
      endcase
    end
  end

  // control, status and read data
  always_comb begin
    enable_d = enable_q;
    msgCnt_d = msgGood ? msgCnt_q + 16'd1 : msgCnt_q;
    badCnt_d = msgBad ? badCnt_q + 16'd1 : badCnt_q;
    regRdData_d = 32'h0000_0000; // unmapped and write-only offsets read zero
    if (regWr && regAddr == `SMHP_REG_CTRL) begin
      enable_d = regWrData[`SMHP_CTRL_EN_BIT];
    end
    if (regRd) begin
      case (regAddr)
        `SMHP_REG_CTRL: regRdData_d = {31'h0, enable_q};
        `SMHP_REG_STATUS: regRdData_d = {badCnt_q, msgCnt_q};
        default: regRdData_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q <= SMHP_IDLE;
      hdrCnt_q <= 5'd0;
      kind_q <= 8'h00;
      flags_q <= 8'h00;
      lenLo_q <= 8'h00;
      left_q <= 16'h0000;
      toEnd_q <= 1'b0;
      deliver_q <= 1'b0;
      first_q <= 1'b0;
      enable_q <= `SMHP_CTRL_RESET;
      msgCnt_q <= 16'h0000;
      badCnt_q <= 16'h0000;
      regRdData_q <= 32'h0000_0000;
    end else begin
      st_q <= st_d;
      hdrCnt_q <= hdrCnt_d;
      kind_q <= kind_d;
      flags_q <= flags_d;
      lenLo_q <= lenLo_d;
      left_q <= left_d;
      toEnd_q <= toEnd_d;
      deliver_q <= deliver_d;
      first_q <= first_d;
      enable_q <= enable_d;
      msgCnt_q <= msgCnt_d;
      badCnt_q <= badCnt_d;
      regRdData_q <= regRdData_d;
    end
  end
  assign regRdData = regRdData_q;

  // receiver context: message start wins over handler updates
  logic [15:0] ver_q, ver_d, ven_q, ven_d;
  logic [95:0] srcP_q, srcP_d, dstP_q, dstP_d;
  logic haveTs_q, haveTs_d;
  logic [63:0] ts_q, ts_d;
  logic [31:0] ucK_q, ucK_d, mcK_q, mcK_d;
  logic [127:0] ucA_q, ucA_d;
  always_comb begin
    ver_d = ver_q;
    ven_d = ven_q;
    srcP_d = srcP_q;
    dstP_d = dstP_q;
    haveTs_d = haveTs_q;
    ts_d = ts_q;
    ucK_d = ucK_q;
    ucA_d = ucA_q;
    mcK_d = mcK_q;
    if (msgStart) begin
      ver_d = `SMHP_PROTO_VER; // see R10
      ven_d = `SMHP_VENDOR_UNKNOWN;
      srcP_d = `SMHP_PREFIX_UNKNOWN;
      dstP_d = localPrefix;
      haveTs_d = 1'b0;
      ts_d = `SMHP_TIME_INVALID;
      ucK_d = transportKind; // see R11
      ucA_d = srcAddrValid ? srcAddr : `SMHP_ADDR_INVALID;
      mcK_d = transportKind; // see R12
    end else begin
      // handlers change the context for later submessages of this message
      if (updSrcValid) begin
        ver_d = updSrcVersion; // see R8
        ven_d = updSrcVendor;
        srcP_d = updSrcPrefix;
      end
      if (updDstValid) begin
        dstP_d = updDstPrefix;
      end
      if (updTsValid) begin
        haveTs_d = updTsHave;
        ts_d = updTs;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ver_q <= `SMHP_PROTO_VER;
      ven_q <= `SMHP_VENDOR_UNKNOWN;
      srcP_q <= `SMHP_PREFIX_UNKNOWN;
      dstP_q <= `SMHP_PREFIX_UNKNOWN;
      haveTs_q <= 1'b0;
      ts_q <= `SMHP_TIME_INVALID;
      ucK_q <= 32'h0000_0000;
      ucA_q <= `SMHP_ADDR_INVALID;
      mcK_q <= 32'h0000_0000;
    end else begin
      ver_q <= ver_d;
      ven_q <= ven_d;
      srcP_q <= srcP_d;
      dstP_q <= dstP_d;
      haveTs_q <= haveTs_d;
      ts_q <= ts_d;
      ucK_q <= ucK_d;
      ucA_q <= ucA_d;
      mcK_q <= mcK_d;
    end
  end
  assign ctxVersion = ver_q;
  assign ctxVendor = ven_q;
  assign ctxSrcPrefix = srcP_q;
  assign ctxDstPrefix = dstP_q;
  assign ctxHaveTs = haveTs_q;
  assign ctxTs = ts_q;
  assign ucKind = ucK_q;
  assign ucAddr = ucA_q;
  assign ucPort = `SMHP_PORT_INVALID; // see R11
  assign mcKind = mcK_q;
  assign mcAddr = `SMHP_ADDR_INVALID; // see R12
  assign mcPort = `SMHP_PORT_INVALID;

  // kind table: software writes {kind, entry}; lookup on the kind byte
  smhp_kind_ram uKindRam (
    .clk(clk),
    .reset(reset),
    .wrEn(ramWr),
    .wrAddr(regWrData[`SMHP_KW_ID_HI:`SMHP_KW_ID_LO]),
    .wrData(regWrData[`SMHP_KW_MASK_HI:`SMHP_KW_MASK_LO]),
    .rdEn(ramRd),
    .rdAddr(inByte),
    .rdData(kindInfo)
  );

  // flags 1..7 pass only where this kind defines them; flag 0 always passes
  assign pushWord = {pushErr, flags_q[`SMHP_E_BIT], first_q, pushLast,
                     flags_q[7:1] & kindInfo[7:1], flags_q[`SMHP_E_BIT], kind_q, inByte}; // see R4 see R3

  smhp_fifo #(.WIDTH(`SMHP_WORD_W), .DEPTH(`SMHP_FIFO_DEPTH)) uFifo (
    .clk(clk),
    .reset(reset),
    .wrValid(pushValid),
    .wrReady(pushReady),
    .wrData(pushWord),
    .rdValid(subValid),
    .rdReady(subReady),
    .rdData(popWord)
  );
  assign subByte = popWord[`SMHP_W_BYTE_LO +: 8];
  assign subKind = popWord[`SMHP_W_KIND_LO +: 8];
  assign subFlags = popWord[`SMHP_W_FLAGS_LO +: 8];
  assign subLast = popWord[`SMHP_W_LAST];
  assign subFirst = popWord[`SMHP_W_FIRST];
  assign subLittle = popWord[`SMHP_W_LITTLE];
  assign subErr = popWord[`SMHP_W_ERR];

  // checks kept beside the logic
  sequence s_idTaken;
    accept && st_q == SMHP_SID && !inLast;
  endsequence
  sequence s_lenTaken;
    accept && st_q == SMHP_SLEN1 && !inLast;
  endsequence
  property p_hdr_order;
    @(posedge clk) disable iff (reset) s_idTaken |=> st_q == SMHP_SFLG;
  endproperty
  a_hdr_order: assert property (p_hdr_order) else $error("kind not followed by flags"); // see R1
  property p_len_order;
    @(posedge clk) disable iff (reset)
      s_lenTaken |=> left_q == ($past(flags_q[0]) ? {$past(inByte), $past(lenLo_q)} : {$past(lenLo_q), $past(inByte)});
  endproperty
  a_len_order: assert property (p_len_order) else $error("length byte order wrong"); // see R15
  property p_zero_len;
    @(posedge clk) disable iff (reset) s_lenTaken ##0 (lenNow == 16'h0000) |=> toEnd_q && st_q == SMHP_BODY;
  endproperty
  a_zero_len: assert property (p_zero_len) else $error("zero length not run to end"); // see R7
  property p_next_sub;
    @(posedge clk) disable iff (reset)
      accept && st_q == SMHP_BODY && !toEnd_q && left_q == 16'd1 && !inLast |=> st_q == SMHP_SID;
  endproperty
  a_next_sub: assert property (p_next_sub) else $error("next header not located"); // see R6
  property p_trunc;
    @(posedge clk) disable iff (reset)
      accept && inLast && (st_q == SMHP_SID || st_q == SMHP_SFLG || st_q == SMHP_SLEN0)
      |=> st_q == SMHP_IDLE && badCnt_q == $past(badCnt_q) + 16'd1;
  endproperty
  a_trunc: assert property (p_trunc) else $error("truncated header not rejected"); // see R13
  property p_skip;
    @(posedge clk) disable iff (reset) accept && st_q == SMHP_BODY && !deliver_q && !subValid |=> !subValid;
  endproperty
  a_skip: assert property (p_skip) else $error("unknown kind forwarded"); // see R14
  property p_ctx_init;
    @(posedge clk) disable iff (reset)
      msgStart |=> ctxVersion == `SMHP_PROTO_VER && ctxVendor == `SMHP_VENDOR_UNKNOWN
      && !ctxHaveTs && ctxTs == `SMHP_TIME_INVALID && ctxDstPrefix == $past(localPrefix);
  endproperty
  a_ctx_init: assert property (p_ctx_init) else $error("context not initialised"); // see R10
  property p_uc_init;
    @(posedge clk) disable iff (reset)
      msgStart |=> ucKind == $past(transportKind) && mcKind == $past(transportKind)
      && ucAddr == ($past(srcAddrValid) ? $past(srcAddr) : `SMHP_ADDR_INVALID);
  endproperty
  a_uc_init: assert property (p_uc_init) else $error("reply locators not initialised"); // see R11
  property p_ctx_keep;
    @(posedge clk) disable iff (reset)
      st_q != SMHP_IDLE && !updSrcValid && !updTsValid |=> $stable(ctxVersion) && $stable(ctxTs);
  endproperty
  a_ctx_keep: assert property (p_ctx_keep) else $error("context lost mid message"); // see R8
endmodule : smhp_parser
`default_nettype wire

// ==== rtl/smhp_consts.svh ====
/*
  constants of the submessage header parser: message layout, receiver initial values,
  register offsets and fields, stream word layout.
  assumes it is included by bare name after the package; holds definitions only.
*/
`ifndef SMHP_CONSTS_SVH
`define SMHP_CONSTS_SVH

// message header bytes skipped before the first submessage
`define SMHP_MSG_HDR_LEN 5'd20
// flag index of the byte-order flag
`define SMHP_E_BIT 0
// receiver initial values, and the length value that runs to the message end
`define SMHP_PROTO_VER 16'h0204
`define SMHP_VENDOR_UNKNOWN 16'h0000
`define SMHP_PREFIX_UNKNOWN 96'h0
`define SMHP_TIME_INVALID 64'hFFFF_FFFF_FFFF_FFFF
`define SMHP_ADDR_INVALID 128'h0
`define SMHP_PORT_INVALID 32'h0
`define SMHP_LEN_TO_END 16'h0000
// register offsets (byte addresses)
`define SMHP_REG_CTRL 4'h0
`define SMHP_REG_STATUS 4'h4
`define SMHP_REG_KIND 4'h8
`define SMHP_CTRL_EN_BIT 0
`define SMHP_CTRL_RESET 1'b1
`define SMHP_KW_ID_HI 15
`define SMHP_KW_ID_LO 8
`define SMHP_KW_MASK_HI 7
`define SMHP_KW_MASK_LO 0
// kind table entry: bit 0 marks a known kind, bits 7:1 the flags that kind uses
`define SMHP_KT_KNOWN_BIT 0
// stream word layout
`define SMHP_WORD_W 28
`define SMHP_FIFO_DEPTH 4
`define SMHP_W_BYTE_LO 0
`define SMHP_W_KIND_LO 8
`define SMHP_W_FLAGS_LO 16
`define SMHP_W_LAST 24
`define SMHP_W_FIRST 25
`define SMHP_W_LITTLE 26
`define SMHP_W_ERR 27

`endif

// ==== rtl/smhp_pkg.sv ====
/*
  types of the submessage header parser.
  assumes nothing beyond a SystemVerilog compiler.
*/
package smhp_pkg;
  // parser states
  typedef enum logic [2:0] {
    SMHP_IDLE = 3'b000,
    SMHP_MHDR = 3'b001,
    SMHP_SID = 3'b010,
    SMHP_SFLG = 3'b011,
    SMHP_SLEN0 = 3'b100,
    SMHP_SLEN1 = 3'b101,
    SMHP_BODY = 3'b110
  } smhp_state_t;
endpackage : smhp_pkg

// ==== rtl/smhp_fifo.sv ====
/*
  small synchronous fifo with valid/ready on both sides.
  assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module smhp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic wrValid,
  output logic wrReady,
  input wire logic [WIDTH-1:0] wrData,
  output logic rdValid,
  input wire logic rdReady,
  output logic [WIDTH-1:0] rdData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH]; // storage, no reset needed
  logic [AW-1:0] wrPtr_q, wrPtr_d; // write pointer
  logic [AW-1:0] rdPtr_q, rdPtr_d; // read pointer
  logic [AW:0] count_q, count_d; // fill level, one bit wider than pointers
  logic doWr, doRd;

  // handshakes: full and empty come straight from the level
  assign wrReady = (count_q < (AW+1)'(DEPTH)); // room left while the level is below the depth
  assign rdValid = (count_q != '0);
  assign rdData = mem_q[rdPtr_q];
  assign doWr = wrValid && wrReady;
  assign doRd = rdValid && rdReady;

  // pointer and level next values; pointers wrap at the depth
  always_comb begin
    wrPtr_d = wrPtr_q;
    rdPtr_d = rdPtr_q;
    count_d = count_q;
    if (doWr) begin
      wrPtr_d = (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
    end
    if (doRd) begin
      rdPtr_d = (rdPtr_q == AW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
    end
    if (doWr && !doRd) begin
      count_d = count_q + 1'b1;
    end else if (doRd && !doWr) begin
      count_d = count_q - 1'b1;
    end
  end

  // register pointers and level
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      count_q <= count_d;
    end
  end

  // storage write
  always_ff @(posedge clk) begin
    if (doWr) begin
      mem_q[wrPtr_q] <= wrData;
    end
  end
endmodule : smhp_fifo
`default_nettype wire

// ==== rtl/smhp_kind_ram.sv ====
/*
  256-entry table of submessage kinds: one byte per kind, registered read.
  assumes one clock; writes come from software, reads from the parser.
*/
`timescale 1ns/1ps
`default_nettype none
module smhp_kind_ram (
  input wire logic clk,
  input wire logic reset,
  input wire logic wrEn,
  input wire logic [7:0] wrAddr,
  input wire logic [7:0] wrData,
  input wire logic rdEn,
  input wire logic [7:0] rdAddr,
  output logic [7:0] rdData
);
  logic [7:0] mem_q [256]; // entries start unknown until software fills them
  logic [7:0] rdData_q, rdData_d; // registered read word

  // read data holds until the next lookup
  always_comb begin
    rdData_d = rdEn ? mem_q[rdAddr] : rdData_q;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdData_q <= 8'h00;
    end else begin
      rdData_q <= rdData_d;
    end
  end

  // table write
  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem_q[wrAddr] <= wrData;
    end
  end

  assign rdData = rdData_q;
endmodule : smhp_kind_ram
`default_nettype wire

// ==== verif/smhp_peer.sv ====
/*
  byte source that stands for the remote participant and its transport.
  assumes the bench builds whole messages and shares clk with the parser.
*/
`timescale 1ns/1ps
`default_nettype none
module smhp_peer (
  input wire logic clk,
  input wire logic inReady,
  output logic [7:0] inByte,
  output logic inValid,
  output logic inLast
);
  // quiet until the first message
  initial begin
    inByte = 8'h00;
    inValid = 1'b0;
    inLast = 1'b0;
  end

  // hands one whole message over and holds each byte until it is taken;
  // gap adds idle cycles between bytes to play a slow sender
  task automatic send(input logic [7:0] m[$], input int gap);
    @(posedge clk);
    for (int i = 0; i < m.size(); i++) begin
      inValid <= 1'b1;
      inByte <= m[i];
      inLast <= (i == m.size() - 1);
      do @(posedge clk); while (inReady !== 1'b1);
      // a released lane shows the inverse, so a stale byte never looks valid
      if (gap > 0 || i == m.size() - 1) begin
        inValid <= 1'b0;
        inLast <= 1'b0;
        inByte <= ~m[i];
        repeat (gap) @(posedge clk);
      end
    end
  endtask : send
endmodule : smhp_peer
`default_nettype wire

// ==== verif/tb.sv ====
/*
  self-checking bench of the submessage header parser.
  assumes smhp_peer as message source and the kind table filled before traffic.
*/
`timescale 1ns/1ps
`default_nettype none
`include "smhp_consts.svh"
module tb;
  logic clk = 1'b0, reset = 1'b1, regWr = 1'b0, regRd = 1'b0, subReady = 1'b1;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWrData = 32'h0, transportKind = 32'h1, regRdData, ucKind, ucPort, mcKind, mcPort;
  logic [127:0] srcAddr = 128'hFACE, ucAddr, mcAddr;
  logic srcAddrValid = 1'b1, updSrcValid = 1'b0, updDstValid = 1'b0, updTsValid = 1'b0, updTsHave = 1'b0;
  logic [15:0] updSrcVersion = 16'h0, updSrcVendor = 16'h0, ctxVersion, ctxVendor;
  logic [95:0] localPrefix = 96'hBEEF, updSrcPrefix = 96'h0, updDstPrefix = 96'h0, ctxSrcPrefix, ctxDstPrefix;
  logic [63:0] updTs = 64'h0, ctxTs;
  logic [7:0] inByte, subByte, subKind, subFlags;
  logic inValid, inLast, inReady, subValid, subFirst, subLast, subLittle, subErr, ctxHaveTs;
  logic [7:0] hdr[$]; // message header bytes, skipped by the parser
  logic [27:0] got[$]; // words taken from the output stream
  int failCount = 0, numChecks = 0, cyc = 0;

  smhp_parser i_smhp_parser (.*);
  smhp_peer i_smhp_peer (.*);

  always #5 clk = ~clk; // 100 MHz

  // hang guard: the run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failCount++;
      summarize();
    end
  end

  // sink: record every word handed over
  always @(posedge clk) begin
    if (subValid === 1'b1 && subReady) begin
      got.push_back({subErr, subLittle, subFirst, subLast, subFlags, subKind, subByte});
    end
  end

  // compare one value, count it, report a mismatch at once
  task automatic chk(input logic [127:0] g, input logic [127:0] e);
    numChecks++;
    if (g !== e) begin
      failCount++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  // one register write
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr

  // one register read; data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 chk(regRdData, e);
  endtask : rd

  // expected output word
  function automatic logic [27:0] w(input logic [7:0] k, f, b, input logic fs, ls, le);
    return {1'b0, le, fs, ls, f, k, b};
  endfunction : w

  // reset values, register map, enable stall, kind table fill
  task automatic t_reset();
    chk(ctxVersion, `SMHP_PROTO_VER);
    chk(ctxTs, `SMHP_TIME_INVALID);
    chk({ctxVendor, ctxSrcPrefix, ctxHaveTs}, 0);
    rd(`SMHP_REG_CTRL, 32'h1);
    rd(`SMHP_REG_STATUS, 32'h0);
    rd(4'hC, 32'h0);
    wr(`SMHP_REG_CTRL, 32'h0);
    #1 chk(inReady, 0);
    wr(`SMHP_REG_CTRL, 32'h1);
    wr(`SMHP_REG_KIND, 32'h1507); // known, uses flags 1 and 2
    wr(`SMHP_REG_KIND, 32'h0901); // known, uses no extra flags
    wr(`SMHP_REG_KIND, 32'h3300); // unknown
    $display("test reset done");
  endtask : t_reset

  // mixed submessages through a stalled sink until the fifo refuses
  task automatic t_order();
    logic [7:0] m[$];
    logic [27:0] e[$];
    m = {hdr, 8'h15, 8'hFF, 8'h03, 8'h00, 8'hA1, 8'hA2, 8'hA3,
      8'h33, 8'h00, 8'h00, 8'h02, 8'h11, 8'h22,
      8'h09, 8'hFE, 8'h00, 8'h01, 8'hB1,
      8'h09, 8'h00, 8'h00, 8'h00, 8'hC1, 8'hC2};
    e = {w(8'h15, 8'h07, 8'hA1, 1, 0, 1), w(8'h15, 8'h07, 8'hA2, 0, 0, 1),
      w(8'h15, 8'h07, 8'hA3, 0, 1, 1), w(8'h09, 8'h00, 8'hB1, 1, 1, 0),
      w(8'h09, 8'h00, 8'hC1, 1, 0, 0), w(8'h09, 8'h00, 8'hC2, 0, 1, 0)};
    got = {};
    subReady <= 1'b0;
    fork
      i_smhp_peer.send(m, 0);
      begin
        repeat (60) @(posedge clk);
        #1 chk(inReady, 0);
        @(posedge clk);
        subReady <= 1'b1;
      end
    join
    repeat (10) @(posedge clk);
    chk(got.size(), 6);
    foreach (e[i]) chk(got[i], e[i]);
    rd(`SMHP_REG_STATUS, 32'h0000_0001);
    chk({ucKind, mcKind}, {transportKind, transportKind});
    chk(ucAddr, srcAddr);
    $display("test order done");
  endtask : t_order

  // context kept after updates, then reset by cut-short messages
  task automatic t_ctx();
    @(posedge clk);
    updSrcValid <= 1'b1;
    updSrcVersion <= 16'h0301;
    updSrcVendor <= 16'h0042;
    updSrcPrefix <= 96'h55;
    updDstValid <= 1'b1;
    updDstPrefix <= 96'h77;
    updTsValid <= 1'b1;
    updTsHave <= 1'b1;
    updTs <= 64'h1234;
    @(posedge clk);
    updSrcValid <= 1'b0;
    updDstValid <= 1'b0;
    updTsValid <= 1'b0;
    srcAddrValid <= 1'b0;
    #1 chk({ctxVersion, ctxDstPrefix, ctxHaveTs}, {16'h0301, 96'h77, 1'b1});
    chk({ctxVendor, ctxSrcPrefix, ctxTs[15:0]}, {16'h0042, 96'h55, 16'h1234});
    i_smhp_peer.send(hdr[0:2], 2);
    i_smhp_peer.send({hdr, 8'h09, 8'h01}, 1);
    repeat (3) @(posedge clk);
    #1 chk({ctxVersion, ctxHaveTs}, {`SMHP_PROTO_VER, 1'b0});
    chk(ctxDstPrefix, localPrefix);
    chk({ucAddr, ucPort}, 0);
    chk({mcAddr, mcPort, mcKind}, transportKind);
    chk({ctxVendor, ctxSrcPrefix}, {`SMHP_VENDOR_UNKNOWN, `SMHP_PREFIX_UNKNOWN});
    chk(ctxTs, `SMHP_TIME_INVALID);
    // unknown kind skipped into an empty fifo, then a known body cut short by the message end
    got = {};
    i_smhp_peer.send({hdr, 8'h33, 8'h00, 8'h00, 8'h01, 8'hEE, 8'h15, 8'h00, 8'h00, 8'h05, 8'hD1}, 0);
    repeat (3) @(posedge clk);
    chk(got.size(), 1);
    chk(got[0], 28'hB0015D1);
    rd(`SMHP_REG_STATUS, 32'h0003_0001);
    $display("test context done");
  endtask : t_ctx

  // verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", numChecks, failCount);
    if (failCount == 0 && numChecks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize

  // reset for 16 cycles, then the scenarios in turn
  initial begin
    repeat (`SMHP_MSG_HDR_LEN) hdr.push_back(8'h5A);
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_order();
    t_ctx();
    summarize();
  end
endmodule : tb
`default_nettype wire
